/* File: bench/ads_diag_sequencer_asserts.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/100ps
`default_nettype none

module ads_diag_sequencer_chk
  import ads_pkg::*;
#(
  parameter int LAMP_CYC  = LAMP_TEST_CYC,
  parameter int FLASH_CYC = FLASH_HALF_CYC
) (
  // Clock, reset, bus
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // Pins, engines, lamps
  input wire logic       pm_present,
  input wire logic [3:0] lb_plug,
  input wire logic       test_req,
  input wire logic [4:0] test_id,
  input wire logic       test_done,
  input wire logic       pm_req,
  input wire logic       pm_handoff,
  input wire ads_lamps_t lamps,
  input wire logic       ext_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bus_answer: assert property (psel && !penable |=> pready)
    else $error("bus answer late");
  a_req_pulse: assert property (test_req |=> !test_req && !pm_req)
    else $error("test request not a pulse");
  a_req_gap: assert property (test_done |=> !test_req)
    else $error("request too soon after done");
  // Port n plug sits at bit n-1; low id bits plus one give that bit
  a_plug_gate: assert property (test_req && test_id inside {[CODE_LB1:CODE_LB4]} |->
    lb_plug[test_id[1:0] + 2'h1] && !ext_out) else $error("loop test without plug");
  a_pm_gate: assert property (pm_req |-> pm_present)
    else $error("module asked while absent");
  a_lamp_test: assert property ($rose(&lamps) |-> (&lamps && !test_req)[*8])
    else $error("lamp check cut short");
  a_handoff_lamp: assert property (pm_handoff [*2] |-> lamps == 6'h20)
    else $error("handoff without steady lamp");
  // Hold length matches the bench FLASH_CYC of 8
  a_flash_hold: assert property ($changed(lamps.good) && $stable(lamps.code) &&
    lamps.code != CODE_NONE |=> $stable(lamps)[*7]) else $error("flash or code unstable");

  c_handoff: cover property ($rose(pm_handoff));
  c_lb4: cover property (test_req && test_id == CODE_LB4);
  c_pm: cover property (pm_req);
endmodule : ads_diag_sequencer_chk

bind ads_diag_sequencer ads_diag_sequencer_chk #(.LAMP_CYC(LAMP_CYC), .FLASH_CYC(FLASH_CYC))
  i_chk (.pclk, .presetn, .psel, .penable, .pready, .pm_present, .lb_plug, .test_req,
  .test_id, .test_done, .pm_req, .pm_handoff, .lamps, .ext_out);

`default_nettype wire

/* File: bench/ads_diag_sequencer_tb.sv */
// Self-checking testbench of the adapter self-test sequencer
`timescale 1ns/100ps
`default_nettype none

module ads_diag_sequencer_tb import ads_pkg::*;;
  localparam int LAMP = 20;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        mode_sw_up = 1'b0, reset_sw = 1'b0, pm_present = 1'b0, pm_bad = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  lb_plug = 4'h0;
  logic [4:0]  fail_id = 5'h00, bad_code = 5'h00, test_id, pm_code;
  logic [1:0]  lat = 2'h0;
  logic [7:0]  req_cnt;
  logic        pready, pslverr, er, test_req, test_done, test_fail;
  logic        pm_req, pm_done, pm_fail, pm_handoff, ext_out;
  ads_lamps_t  lamps;
  int          miscompares = 0, cmp_count = 0, cyc = 0;
  logic [4:0]  lp [9] = '{CODE_ROM, CODE_RAM, CODE_LB1, CODE_LB2, CODE_LB3, CODE_LB4,
                          CODE_COMM, CODE_NEG, CODE_WDOG};
  logic [4:0]  sp [6] = '{CODE_ROM, CODE_RAM, CODE_CPU, CODE_COMM, CODE_NEG, CODE_WDOG};

  always #2 pclk = ~pclk;

  ads_diag_sequencer #(.LAMP_CYC(LAMP), .FLASH_CYC(8)) i_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_sw_up, .reset_sw,
    .pm_present, .lb_plug, .test_req, .test_id, .test_done, .test_fail, .pm_req, .pm_done,
    .pm_fail, .pm_code, .pm_handoff, .lamps, .ext_out);
  ads_far_model i_far (.pclk, .presetn, .test_req, .test_id, .pm_req, .test_done,
    .test_fail, .pm_done, .pm_fail, .pm_code, .fail_id, .lat, .pm_bad, .bad_code, .req_cnt);

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Bounds the whole run; about a tenth of it is used
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rst(input logic mu, input logic pm, input logic [3:0] pl, input logic [4:0] f);
    presetn    <= 1'b0;
    mode_sw_up <= mu;
    pm_present <= pm;
    lb_plug    <= pl;
    fail_id    <= f;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst

  task automatic wait_done();
    rd = 32'h0;
    for (int i = 0; i < 400 && rd[7] !== 1'b1; i++) apb(1'b0, OFS_STATUS, 32'h0);
    @(posedge pclk);
  endtask : wait_done

  // Code on status and lamps, then health lamp changes over 24 cycles
  task automatic done_chk(input logic [4:0] code, input int fl);
    int   c;
    logic g;
    c = 0;
    check(rd[4:0], code);
    check(lamps.code, code);
    g = lamps.good;
    repeat (24) begin
      @(posedge pclk);
      if (lamps.good !== g) c++;
      g = lamps.good;
    end
    check(c, fl);
  endtask : done_chk

  task automatic sc_lamp();
    int n;
    n = 0;
    rst(1'b1, 1'b1, 4'hF, CODE_NONE);
    for (int i = 0; i < 50 && lamps !== 6'h3F; i++) @(posedge pclk);
    while (lamps === 6'h3F && n < 99) begin
      @(posedge pclk);
      n++;
    end
    check(n, LAMP);
    check(lamps, 6'h00);
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_done();
    check(rd[6], 1'b1);
    done_chk(CODE_NONE, 3);
    check(req_cnt, 9);
    check(pm_handoff, 1'b0);
    check(ext_out, 1'b0);
  endtask : sc_lamp

  task automatic sc_loop_fail();
    for (int i = 0; i < 9; i++) begin
      lat <= 2'(i);
      rst(1'b1, 1'b1, 4'hF, lp[i]);
      wait_done();
      done_chk(lp[i], 3);
      check(req_cnt, i + 1);
    end
  endtask : sc_loop_fail

  task automatic sc_plug();
    for (int k = 0; k < 5; k++) begin
      rst(1'b1, 1'b0, ~(4'h1 << k), CODE_NONE);
      wait_done();
      done_chk(k < 4 ? CODE_LB1 + 5'(k) : CODE_PM, 3);
      check(req_cnt, k < 4 ? k + 2 : 9);
    end
  endtask : sc_plug

  task automatic sc_start_fail();
    for (int i = 0; i < 6; i++) begin
      rst(1'b0, 1'b1, 4'h0, sp[i]);
      wait_done();
      check(rd[6], 1'b0);
      done_chk(sp[i], 3);
      check(pm_handoff, 1'b0);
    end
  endtask : sc_start_fail

  task automatic sc_start_pass();
    pm_bad   <= 1'b1;
    bad_code <= 5'h15;
    rst(1'b0, 1'b1, 4'h0, CODE_NONE);
    wait_done();
    done_chk(5'h15, 3);
    pm_bad <= 1'b0;
    rst(1'b0, 1'b1, 4'h0, CODE_NONE);
    wait_done();
    done_chk(CODE_NONE, 0);
    check(lamps, 6'h20);
    check(pm_handoff, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h1);
    check(ext_out, 1'b1);
    reset_sw <= 1'b1;
    for (int i = 0; i < 20 && lamps !== 6'h3F; i++) @(posedge pclk);
    check(lamps, 6'h3F);
    reset_sw <= 1'b0;
    wait_done();
    check(pm_handoff, 1'b1);
  endtask : sc_start_pass

  task automatic sc_apb();
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    check(er, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, OFS_LAMPS, 32'h0);
    check(rd, 32'h20);
  endtask : sc_apb

  initial begin
    repeat (3) @(posedge pclk);
    sc_lamp();
    sc_loop_fail();
    sc_plug();
    sc_start_fail();
    sc_start_pass();
    sc_apb();
    stop_test();
  end
endmodule : ads_diag_sequencer_tb

`default_nettype wire

/* File: bench/ads_far_model.sv */
// Far-side model: test engine and personality module answering the sequencer
`timescale 1ns/100ps
`default_nettype none

module ads_far_model
  import ads_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Sequencer side
  input  wire logic       test_req,
  input  wire logic [4:0] test_id,
  input  wire logic       pm_req,
  output var  logic       test_done,
  output var  logic       test_fail,
  output var  logic       pm_done,
  output var  logic       pm_fail,
  output var  logic [4:0] pm_code,
  // Scenario controls
  input  wire logic [4:0] fail_id,
  input  wire logic [1:0] lat,
  input  wire logic       pm_bad,
  input  wire logic [4:0] bad_code,
  output var  logic [7:0] req_cnt
);
  logic [1:0] t_cnt;
  logic       t_busy;
  logic       p_busy;

  // Outside a done pulse the answer lines carry the opposite value
  assign test_fail = test_done ~^ (test_id == fail_id);
  assign pm_fail   = pm_done ~^ pm_bad;
  assign pm_code   = pm_done ? bad_code : ~bad_code;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_busy    <= 1'b0;
      t_cnt     <= 2'h0;
      test_done <= 1'b0;
      req_cnt   <= 8'h00;
      p_busy    <= 1'b0;
      pm_done   <= 1'b0;
    end else begin
      test_done <= 1'b0;
      p_busy    <= pm_req;
      pm_done   <= p_busy;
      if (test_req) begin
        t_busy  <= 1'b1;
        t_cnt   <= lat;
        req_cnt <= req_cnt + 8'h01;
      end else if (t_busy && t_cnt == 2'h0) begin
        t_busy    <= 1'b0;
        test_done <= 1'b1;
      end else if (t_busy) begin
        t_cnt <= t_cnt - 2'h1;
      end
    end
  end
endmodule : ads_far_model

`default_nettype wire

/* File: rtl/ads_diag_sequencer.sv */
// Adapter self-test sequencer with APB status and control
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module ads_diag_sequencer
  import ads_pkg::*;
#(
  parameter int LAMP_CYC  = LAMP_TEST_CYC,
  parameter int FLASH_CYC = FLASH_HALF_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Pins (asynchronous)
  input  wire logic              mode_sw_up,
  input  wire logic              reset_sw,
  input  wire logic              pm_present,
  input  wire logic [3:0]        lb_plug,
  // Test engine
  output var  logic              test_req,
  output var  logic [4:0]        test_id,
  input  wire logic              test_done,
  input  wire logic              test_fail,
  // Personality module
  output var  logic              pm_req,
  input  wire logic              pm_done,
  input  wire logic              pm_fail,
  input  wire logic [4:0]        pm_code,
  output var  logic              pm_handoff,
  // Lamps and external output
  output var  ads_lamps_t        lamps,
  output var  logic              ext_out
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic             rsw_d_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      rsw_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {lb_plug, pm_present, reset_sw, mode_sw_up};
      sync2_reg <= sync1_reg;
      rsw_d_reg <= sync2_reg[1];
    end
  end

  logic       mode_up_s;
  logic       pm_fit_s;
  logic [3:0] plug_s;
  logic       rsw_press;
  assign mode_up_s = sync2_reg[0];
  assign pm_fit_s  = sync2_reg[2];
  assign plug_s    = sync2_reg[6:3];
  assign rsw_press = sync2_reg[1] & ~rsw_d_reg;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic        ctrl_ext_reg;
  logic        restart_reg;
  logic        wr_en;
  logic        setup;
  logic        mapped;
  logic [31:0] rd_word;
  ads_state_t  state_reg;
  logic        loop_reg;
  logic        failed_reg;
  logic [4:0]  err_code_reg;

  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pready & pwrite;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_LAMPS);

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: begin
        rd_word[CTRL_EXT] = ctrl_ext_reg;
      end
      OFS_STATUS: begin
        rd_word[4:0]         = err_code_reg;
        rd_word[ST_LOOP_BIT] = loop_reg;
        rd_word[ST_DONE_BIT] = (state_reg == ADS_DONE);
        rd_word[ST_FAIL_BIT] = failed_reg;
        rd_word[ST_HAND_BIT] = pm_handoff;
        rd_word[ST_STATE_LO +: 3] = state_reg;
      end
      OFS_LAMPS: begin
        rd_word[5:0] = lamps;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // One wait-free access cycle: answer prepared in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ext_reg <= 1'b0;
      restart_reg  <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (wr_en && paddr == OFS_CTRL) begin
        ctrl_ext_reg <= pwdata[CTRL_EXT];
        restart_reg  <= pwdata[CTRL_RSTRT];
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [TMR_W-1:0] tmr_reg;
  logic [3:0]       idx_reg;
  logic             restart;
  logic [4:0]       cur_code;
  logic             plug_miss;
  logic             fail_now;
  logic [4:0]       fail_code;

  assign restart  = rsw_press | restart_reg; // [RULE3]
  assign cur_code = ads_step_code(loop_reg, idx_reg); // [RULE5] [RULE13] [RULE16]
  // Port n plug sits at bit n-1 of the synchronised plug bits
  assign plug_miss = ads_is_loop(cur_code) && !plug_s[2'(cur_code - CODE_LB1)]; // [RULE7]

  // ----------------------------------------
  // Failure events
  // ----------------------------------------
  // One place decides what ends a run with an error, so the
  // state machine and the error record cannot disagree
  always_comb begin
    fail_now  = 1'b0;
    fail_code = CODE_NONE;
    unique case (state_reg)
      ADS_ISSUE: begin
        if (cur_code == CODE_NONE) begin
          fail_now  = ~pm_fit_s;
          fail_code = CODE_PM; // [RULE14]
        end else if (plug_miss) begin
          fail_now  = 1'b1;
          fail_code = cur_code; // [RULE11]
        end
      end
      ADS_WAIT: begin
        fail_now  = test_done & test_fail;
        fail_code = test_id; // [RULE6] [RULE12]
      end
      ADS_PM_WAIT: begin
        fail_now  = pm_done & pm_fail;
        fail_code = pm_code; // [RULE17]
      end
      default: begin
        fail_now  = 1'b0;
        fail_code = CODE_NONE;
      end
    endcase
  end

  // Only the first failure is kept; no state after it raises fail_now
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      failed_reg   <= 1'b0;
      err_code_reg <= CODE_NONE;
    end else if (restart) begin
      failed_reg   <= 1'b0;
      err_code_reg <= CODE_NONE;
    end else if (fail_now) begin
      failed_reg   <= 1'b1;
      err_code_reg <= fail_code; // [RULE6]
    end
  end

  // Handoff only after a clean startup run with the module answering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_handoff <= 1'b0;
    end else if (restart) begin
      pm_handoff <= 1'b0;
    end else if (state_reg == ADS_PM_WAIT && pm_done && !pm_fail) begin
      pm_handoff <= ~loop_reg; // [RULE20]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ADS_START; // [RULE3]
      tmr_reg   <= '0;
      idx_reg   <= 4'h0;
      loop_reg  <= 1'b0;
      test_req  <= 1'b0;
      test_id   <= CODE_NONE;
      pm_req    <= 1'b0;
    end else begin
      test_req <= 1'b0;
      pm_req   <= 1'b0;
      if (restart) begin
        state_reg <= ADS_START; // [RULE3]
        tmr_reg   <= '0;
        idx_reg   <= 4'h0;
      end else begin
        unique case (state_reg)
          // Wait for the switch synchronisers to fill before sampling
          ADS_START: begin
            tmr_reg <= tmr_reg + 1'b1;
            if (tmr_reg == SYNC_SETTLE) begin
              loop_reg  <= mode_up_s; // [RULE1] [RULE2]
              tmr_reg   <= '0;
              state_reg <= ADS_LAMP;
            end
          end
          ADS_LAMP: begin
            tmr_reg <= tmr_reg + 1'b1;
            if (tmr_reg == TMR_W'(LAMP_CYC - 1)) begin // [RULE21]
              state_reg <= ADS_ISSUE;
            end
          end
          ADS_ISSUE: begin
            if (fail_now) begin
              state_reg <= ADS_DONE;
            end else if (cur_code == CODE_NONE) begin
              state_reg <= ADS_PM_REQ;
            end else begin
              test_req  <= 1'b1;
              test_id   <= cur_code; // [RULE12]
              state_reg <= ADS_WAIT;
            end
          end
          ADS_WAIT: begin
            if (fail_now) begin
              state_reg <= ADS_DONE; // [RULE6]
            end else if (test_done) begin
              idx_reg   <= idx_reg + 1'b1;
              state_reg <= ADS_ISSUE;
            end
          end
          ADS_PM_REQ: begin
            pm_req    <= 1'b1;
            state_reg <= ADS_PM_WAIT;
          end
          ADS_PM_WAIT: begin
            if (pm_done) begin
              state_reg <= ADS_DONE;
            end
          end
          // Held here until the next reset, reset-switch press or software restart
          ADS_DONE: begin
            state_reg <= ADS_DONE; // [RULE15]
          end
          default: begin
            state_reg <= ADS_START;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Flash divider
  // ----------------------------------------
  logic [TMR_W-1:0] fl_cnt_reg;
  logic             fl_phase_reg;

  // Free running; phase of the first flash is not aligned to the end of tests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_cnt_reg   <= '0;
      fl_phase_reg <= 1'b0;
    end else if (fl_cnt_reg == TMR_W'(FLASH_CYC - 1)) begin
      fl_cnt_reg   <= '0;
      fl_phase_reg <= ~fl_phase_reg; // [RULE22]
    end else begin
      fl_cnt_reg <= fl_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // Lamps and external output
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamps <= '0;
    end else begin
      unique case (state_reg)
        ADS_LAMP: begin
          lamps <= '1; // [RULE21]
        end
        ADS_DONE: begin
          lamps.code <= err_code_reg; // [RULE9] [RULE10] [RULE19]
          if (loop_reg || failed_reg) begin
            lamps.good <= fl_phase_reg; // [RULE8] [RULE19]
          end else begin
            lamps.good <= 1'b1; // [RULE18]
          end
        end
        default: begin
          lamps <= '0; // [RULE21]
        end
      endcase
    end
  end

  // Loopback mode keeps the output off whatever software asks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_out <= 1'b0;
    end else begin
      ext_out <= ctrl_ext_reg & ~loop_reg & (state_reg != ADS_START); // [RULE4]
    end
  end

endmodule : ads_diag_sequencer

`default_nettype wire

/* File: rtl/ads_pkg.sv */
// Constants, types and step table of the adapter self-test sequencer
//
// Overview of operation
// [RULE1] Switch up at reset: loopback mode
// [RULE2] Switch down at reset: startup mode
// [RULE3] Power-up and reset press restart sequence
// [RULE4] Loopback mode forces external output off
// [RULE5] Loopback runs all tests, module or not
// [RULE6] Stop at first failure, keep code
// [RULE7] Missing loopback plug fails that port
// [RULE8] Loopback end: health lamp flashes 2 Hz
// [RULE9] Loopback pass: code lamps all off
// [RULE10] Code on lamps 2-6, lamp 2 MSB
// [RULE11] Port loopback codes 00011 to 00110
// [RULE12] Common codes for ROM, RAM, comms, etc
// [RULE13] Startup adds processor code, no ports
// [RULE14] All pass, module absent: module code
// [RULE15] Loopback end halts until next reset
// [RULE16] Startup tests need no port cables
// [RULE17] Module failure code shown on lamps
// [RULE18] Startup pass: health steady, others off
// [RULE19] Startup fail: flash health, show code
// [RULE20] Startup pass with module: hand over
// [RULE21] All lamps on 1 s, then off
// [RULE22] Flash 250 ms on, 250 ms off
package ads_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ        = 250000;
  localparam int LAMP_TEST_MS   = 1000;
  localparam int FLASH_HALF_MS  = 250;
  localparam int LAMP_TEST_CYC  = LAMP_TEST_MS * CLK_KHZ;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;
  localparam int TMR_W          = 28;
  localparam logic [TMR_W-1:0] SYNC_SETTLE = 28'h0000003;

  // ----------------------------------------
  // Error codes
  // ----------------------------------------
  localparam logic [4:0] CODE_NONE = 5'h00;
  localparam logic [4:0] CODE_ROM  = 5'h01;
  localparam logic [4:0] CODE_RAM  = 5'h02;
  localparam logic [4:0] CODE_LB1  = 5'h03;
  localparam logic [4:0] CODE_LB2  = 5'h04;
  localparam logic [4:0] CODE_LB3  = 5'h05;
  localparam logic [4:0] CODE_LB4  = 5'h06;
  localparam logic [4:0] CODE_COMM = 5'h07;
  localparam logic [4:0] CODE_PM   = 5'h08;
  localparam logic [4:0] CODE_CPU  = 5'h09;
  localparam logic [4:0] CODE_NEG  = 5'h0A;
  localparam logic [4:0] CODE_WDOG = 5'h0B;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int         ADDR_W      = 12;
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_LAMPS  = 12'h008;
  localparam int         CTRL_EXT    = 0;
  localparam int         CTRL_RSTRT  = 1;
  localparam int         ST_LOOP_BIT = 6;
  localparam int         ST_DONE_BIT = 7;
  localparam int         ST_FAIL_BIT = 8;
  localparam int         ST_HAND_BIT = 9;
  localparam int         ST_STATE_LO = 10;

  typedef enum logic [2:0] {
    ADS_START   = 3'h0,
    ADS_LAMP    = 3'h1,
    ADS_ISSUE   = 3'h2,
    ADS_WAIT    = 3'h3,
    ADS_PM_REQ  = 3'h4,
    ADS_PM_WAIT = 3'h5,
    ADS_DONE    = 3'h6
  } ads_state_t;

  typedef struct packed {
    logic       good;
    logic [4:0] code;
  } ads_lamps_t;

  // Test order per mode; CODE_NONE ends the list
  function automatic logic [4:0] ads_step_code(input logic loop, input logic [3:0] idx);
    logic [4:0] c;
    c = CODE_NONE;
    if (loop) begin
      case (idx)
        4'h0: c = CODE_ROM;
        4'h1: c = CODE_RAM;
        4'h2: c = CODE_LB1;
        4'h3: c = CODE_LB2;
        4'h4: c = CODE_LB3;
        4'h5: c = CODE_LB4;
        4'h6: c = CODE_COMM;
        4'h7: c = CODE_NEG;
        4'h8: c = CODE_WDOG;
        default: c = CODE_NONE;
      endcase
    end else begin
      case (idx)
        4'h0: c = CODE_ROM;
        4'h1: c = CODE_RAM;
        4'h2: c = CODE_CPU;
        4'h3: c = CODE_COMM;
        4'h4: c = CODE_NEG;
        4'h5: c = CODE_WDOG;
        default: c = CODE_NONE;
      endcase
    end
    return c;
  endfunction : ads_step_code

  function automatic logic ads_is_loop(input logic [4:0] c);
    return (c >= CODE_LB1) && (c <= CODE_LB4);
  endfunction : ads_is_loop

endpackage : ads_pkg
